//--- inc/scx_pkg.sv
// Shared constants, opcodes and carrier types for the smart-card execution core
package scx_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int INSTR_CYCLE_NS = 400;
  localparam int CLKS_PER_CYCLE = INSTR_CYCLE_NS / CLK_PERIOD_NS;

  // Register port map (word indices)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_MEM_ADDR = 4'h2;
  localparam logic [3:0] REG_MEM_DATA = 4'h3;
  localparam logic [3:0] REG_PC = 4'h4;
  localparam logic [3:0] REG_ACC = 4'h5;
  localparam logic [3:0] REG_STACK = 4'h6;
  localparam logic [3:0] REG_PTR = 4'h7;
  localparam int CTRL_RUN_BIT = 0;
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_ILL_BIT = 1;

  localparam logic [7:0] RESET_SP = 8'hFF;
  localparam logic [7:0] ZERO_PAGE_VECTOR = 8'h10;

  // Opcode encoding
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_BR_ZERO = 8'h01;
  localparam logic [7:0] OP_BR_NOT_ZERO = 8'h02;
  localparam logic [7:0] OP_BR_CARRY = 8'h03;
  localparam logic [7:0] OP_BR_NO_CARRY = 8'h04;
  localparam logic [7:0] OP_BR_BIT_SET = 8'h05;
  localparam logic [7:0] OP_BR_BIT_CLEAR = 8'h06;
  localparam logic [7:0] OP_DEC_BR_R4 = 8'h08;
  localparam logic [7:0] OP_BR_MEM_NE = 8'h0C;
  localparam logic [7:0] OP_BR_PTR_NE = 8'h0D;
  localparam logic [7:0] OP_CALL = 8'h10;
  localparam logic [7:0] OP_CALL_ZP = 8'h11;
  localparam logic [7:0] OP_RETURN = 8'h12;
  localparam logic [7:0] OP_PUSH_STATUS = 8'h13;
  localparam logic [7:0] OP_POP_STATUS = 8'h14;
  localparam logic [7:0] OP_PARITY_CHK = 8'h15;
  localparam logic [7:0] OP_CMP_IND = 8'h18;
  localparam logic [7:0] OP_CMP_DIR = 8'h19;
  localparam logic [7:0] OP_CMP_IMM = 8'h1A;
  localparam logic [7:0] OP_CMP_MEM_MEM = 8'h1B;
  localparam logic [7:0] OP_AND_IND = 8'h1C;
  localparam logic [7:0] OP_AND_DIR = 8'h1D;
  localparam logic [7:0] OP_AND_IMM = 8'h1E;
  localparam logic [7:0] OP_SW_DELAY = 8'h1F;
  localparam logic [7:0] OP_LOAD_ACC = 8'h20;
  localparam logic [7:0] OP_LOAD_PTR = 8'h21;
  localparam logic [7:0] OP_LOAD_B = 8'h22;
  localparam logic [7:0] OP_LOAD_R4 = 8'h30;

  // Cycle counts in instruction cycles
  localparam logic [8:0] CYC_1 = 9'h001;
  localparam logic [8:0] CYC_2 = 9'h002;
  localparam logic [8:0] CYC_3 = 9'h003;
  localparam logic [8:0] CYC_4 = 9'h004;
  localparam logic [8:0] DELAY_EXTRA = 9'h003;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_WAIT = 2'b10
  } scx_state_t;

  typedef struct packed {
    logic [3:0] rsv;
    logic z;
    logic h;
    logic p;
    logic c;
  } scx_ccr_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } scx_bus_req_t;
endpackage : scx_pkg

//--- logic/scx_core.sv
// Smart-card execution core: fetch, execute and cycle timing with a plain register port
`timescale 1ns/1ps
module scx_core import scx_pkg::*; (
  input wire logic clock,
  input wire logic reset_n,
  input wire scx_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  output logic running,
  output logic illegal_op
);

  logic [7:0] mem [0:255];

  scx_state_t state_r, state_nxt;
  logic [11:0] cnt_r, cnt_nxt;
  logic [7:0] pc_r, pc_nxt;
  logic [7:0] acc_r, acc_nxt;
  logic [7:0] b_r, b_nxt;
  logic [7:0] ptr_r, ptr_nxt;
  logic [7:0] stack_pointer_r, stack_pointer_nxt;
  logic [7:0] gpr_r [0:3];
  logic [7:0] gpr_nxt [0:3];
  scx_ccr_t ccr_r, ccr_nxt;
  logic run_r, run_nxt;
  logic ill_r, ill_nxt;
  logic [7:0] maddr_r, maddr_nxt;
  logic [7:0] rdata_r, rdata_nxt;

  logic we1, we2;
  logic [7:0] wa1, wd1, wa2, wd2;
  logic [7:0] op, b1, b2, ind, dir, bitbyte, dec_val;
  logic [8:0] cyc;
  logic take;
  logic host_mem_wr;

  always_comb begin
    pc_nxt = pc_r;
    acc_nxt = acc_r;
    b_nxt = b_r;
    ptr_nxt = ptr_r;
    stack_pointer_nxt = stack_pointer_r;
    for (int i = 0; i < 4; i++) begin
      gpr_nxt[i] = gpr_r[i];
    end
    ccr_nxt = ccr_r;
    run_nxt = run_r;
    ill_nxt = ill_r;
    maddr_nxt = maddr_r;
    we1 = 1'b0;
    we2 = 1'b0;
    wa1 = 8'h00;
    wd1 = 8'h00;
    wa2 = 8'h00;
    wd2 = 8'h00;
    cyc = CYC_1;
    take = 1'b0;
    op = mem[pc_r];
    b1 = mem[pc_r + 8'h01];
    b2 = mem[pc_r + 8'h02];
    ind = mem[ptr_r];
    dir = mem[b1];
    bitbyte = mem[{3'b000, b1[7:3]}];
    dec_val = gpr_r[op[1:0]] - 8'h01;

    case (state_r)
      ST_EXEC: begin
        pc_nxt = pc_r + 8'h01;
        case (op)
          OP_NOP: begin
            cyc = CYC_1;
          end
          OP_BR_ZERO, OP_BR_NOT_ZERO, OP_BR_CARRY, OP_BR_NO_CARRY: begin
            case (op)
              OP_BR_ZERO: take = ccr_r.z;
              OP_BR_NOT_ZERO: take = !ccr_r.z;
              OP_BR_CARRY: take = ccr_r.c;
              default: take = !ccr_r.c;
            endcase
            pc_nxt = take ? pc_r + 8'h02 + b1 : pc_r + 8'h02;
            cyc = take ? CYC_3 : CYC_2;
          end
          OP_BR_BIT_SET, OP_BR_BIT_CLEAR: begin
            take = bitbyte[b1[2:0]] == (op == OP_BR_BIT_SET);
            pc_nxt = take ? pc_r + 8'h03 + b2 : pc_r + 8'h03;
            cyc = take ? CYC_4 : CYC_3;
          end
          OP_DEC_BR_R4, 8'h09, 8'h0A, 8'h0B: begin
            gpr_nxt[op[1:0]] = dec_val;
            take = dec_val == 8'h00;
            pc_nxt = take ? pc_r + 8'h02 + b1 : pc_r + 8'h02;
            cyc = take ? CYC_4 : CYC_3;
          end
          OP_BR_MEM_NE, OP_BR_PTR_NE: begin
            take = (op == OP_BR_MEM_NE) ? (ind != b1) : (ptr_r != b1);
            pc_nxt = take ? pc_r + 8'h03 + b2 : pc_r + 8'h03;
            cyc = take ? CYC_4 : CYC_3;
          end
          OP_CALL, OP_CALL_ZP: begin
            // Return byte at SP, zero high byte below it
            we1 = 1'b1;
            wa1 = stack_pointer_r;
            wd1 = pc_r + 8'h02;
            we2 = 1'b1;
            wa2 = stack_pointer_r - 8'h01;
            wd2 = 8'h00;
            pc_nxt = (op == OP_CALL) ? b1 : ZERO_PAGE_VECTOR;
            stack_pointer_nxt = stack_pointer_r - 8'h02;
            cyc = CYC_4;
          end
          OP_RETURN: begin
            pc_nxt = mem[stack_pointer_r + 8'h02];
            stack_pointer_nxt = stack_pointer_r + 8'h02;
            cyc = CYC_3;
          end
          OP_PUSH_STATUS: begin
            we1 = 1'b1;
            wa1 = stack_pointer_r;
            wd1 = acc_r;
            we2 = 1'b1;
            wa2 = stack_pointer_r - 8'h01;
            wd2 = ccr_r;
            stack_pointer_nxt = stack_pointer_r - 8'h02;
            cyc = CYC_3;
          end
          OP_POP_STATUS: begin
            // Mirror of the push layout; A, C, P and H round-trip but Z keeps its current value
            ccr_nxt.c = mem[stack_pointer_r + 8'h01][0];
            ccr_nxt.p = mem[stack_pointer_r + 8'h01][1];
            ccr_nxt.h = mem[stack_pointer_r + 8'h01][2];
            acc_nxt = mem[stack_pointer_r + 8'h02];
            stack_pointer_nxt = stack_pointer_r + 8'h02;
            cyc = CYC_3;
          end
          OP_PARITY_CHK: begin
            ccr_nxt.p = ccr_r.c;
            ccr_nxt.c = ^acc_r;
            cyc = CYC_1;
          end
          OP_CMP_IND: begin
            ccr_nxt.c = acc_r < ind;
            ccr_nxt.z = acc_r == ind;
            cyc = CYC_1;
          end
          OP_CMP_DIR: begin
            ccr_nxt.c = acc_r < dir;
            ccr_nxt.z = acc_r == dir;
            pc_nxt = pc_r + 8'h02;
            cyc = CYC_2;
          end
          OP_CMP_IMM: begin
            ccr_nxt.c = acc_r < b1;
            ccr_nxt.z = acc_r == b1;
            pc_nxt = pc_r + 8'h02;
            cyc = CYC_2;
          end
          OP_CMP_MEM_MEM: begin
            // BA pair addresses 256 bytes only: low byte A selects
            ccr_nxt.c = ind < mem[acc_r];
            ccr_nxt.z = ind == mem[acc_r];
            cyc = CYC_4;
          end
          OP_AND_IND: begin
            acc_nxt = acc_r & ind;
            cyc = CYC_1;
          end
          OP_AND_DIR: begin
            acc_nxt = acc_r & dir;
            ccr_nxt.z = (acc_r & dir) == 8'h00;
            pc_nxt = pc_r + 8'h02;
            cyc = CYC_2;
          end
          OP_AND_IMM: begin
            acc_nxt = acc_r & b1;
            ccr_nxt.z = (acc_r & b1) == 8'h00;
            pc_nxt = pc_r + 8'h02;
            cyc = CYC_2;
          end
          OP_SW_DELAY: begin
            pc_nxt = pc_r + 8'h02;
            cyc = {1'b0, b1} + DELAY_EXTRA;
          end
          OP_LOAD_ACC: begin
            acc_nxt = b1;
            ccr_nxt.z = b1 == 8'h00;
            pc_nxt = pc_r + 8'h02;
            cyc = CYC_2;
          end
          OP_LOAD_PTR: begin
            ptr_nxt = b1;
            pc_nxt = pc_r + 8'h02;
            cyc = CYC_2;
          end
          OP_LOAD_B: begin
            b_nxt = b1;
            pc_nxt = pc_r + 8'h02;
            cyc = CYC_2;
          end
          OP_LOAD_R4, 8'h31, 8'h32, 8'h33: begin
            gpr_nxt[op[1:0]] = b1;
            pc_nxt = pc_r + 8'h02;
            cyc = CYC_3;
          end
          default: begin
            // Unknown opcode halts so a stray fetch cannot run wild
            pc_nxt = pc_r;
            ill_nxt = 1'b1;
            run_nxt = 1'b0;
          end
        endcase
      end
      default: begin
      end
    endcase

    // Register port; PC, pointer and stack writes only while stopped
    if (bus_req.wr) begin
      case (bus_req.addr)
        REG_CTRL: run_nxt = bus_req.wdata[CTRL_RUN_BIT];
        REG_STATUS: begin
          // Hardware set in the same cycle wins over the clear
          if (bus_req.wdata[STAT_ILL_BIT] && !(state_r == ST_EXEC && ill_nxt && !ill_r)) begin
            ill_nxt = 1'b0;
          end
        end
        REG_MEM_ADDR: maddr_nxt = bus_req.wdata;
        REG_MEM_DATA: maddr_nxt = maddr_r + 8'h01;
        REG_PC: begin
          if (state_r == ST_IDLE) begin
            pc_nxt = bus_req.wdata;
          end
        end
        REG_STACK: begin
          if (state_r == ST_IDLE) begin
            stack_pointer_nxt = bus_req.wdata;
          end
        end
        REG_PTR: begin
          if (state_r == ST_IDLE) begin
            ptr_nxt = bus_req.wdata;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Instruction cycle timer: one EXEC clock, then the rest of the cycle count in WAIT
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      ST_IDLE: begin
        if (run_r) begin
          state_nxt = ST_EXEC;
        end
      end
      ST_EXEC: begin
        // Illegal opcodes still spend one cycle before halting
        cnt_nxt = 12'(cyc * CLKS_PER_CYCLE - 1);
        state_nxt = ST_WAIT;
      end
      ST_WAIT: begin
        // Counting down to 1 lets the last WAIT clock hand over to EXEC
        if (cnt_r == 12'h001) begin
          // Stop request is honoured only at an instruction boundary
          state_nxt = run_r ? ST_EXEC : ST_IDLE;
        end else begin
          cnt_nxt = cnt_r - 12'h001;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      cnt_r <= 12'h000;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Read reply stands one clock only; an idle bus reads back zero
  always_comb begin
    rdata_nxt = 8'h00;
    if (bus_req.rd) begin
      case (bus_req.addr)
        REG_CTRL: rdata_nxt = {7'h00, run_r};
        REG_STATUS: rdata_nxt = {ccr_r[3:0], 2'b00, ill_r, state_r != ST_IDLE};
        REG_MEM_ADDR: rdata_nxt = maddr_r;
        REG_MEM_DATA: rdata_nxt = mem[maddr_r];
        REG_PC: rdata_nxt = pc_r;
        REG_ACC: rdata_nxt = acc_r;
        REG_STACK: rdata_nxt = stack_pointer_r;
        REG_PTR: rdata_nxt = ptr_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pc_r <= 8'h00;
      acc_r <= 8'h00;
      b_r <= 8'h00;
      ptr_r <= 8'h00;
      stack_pointer_r <= RESET_SP;
      for (int i = 0; i < 4; i++) begin
        gpr_r[i] <= 8'h00;
      end
      ccr_r <= '0;
      run_r <= 1'b0;
      ill_r <= 1'b0;
      maddr_r <= 8'h00;
    end else begin
      pc_r <= pc_nxt;
      acc_r <= acc_nxt;
      b_r <= b_nxt;
      ptr_r <= ptr_nxt;
      stack_pointer_r <= stack_pointer_nxt;
      for (int i = 0; i < 4; i++) begin
        gpr_r[i] <= gpr_nxt[i];
      end
      ccr_r <= ccr_nxt;
      run_r <= run_nxt;
      ill_r <= ill_nxt;
      maddr_r <= maddr_nxt;
    end
  end

  // Host load beats a core stack write in the same clock
  assign host_mem_wr = bus_req.wr && bus_req.addr == REG_MEM_DATA;

  // Memory has no reset; software loads it before setting run
  always_ff @(posedge clock) begin
    if (host_mem_wr) begin
      mem[maddr_r] <= bus_req.wdata;
    end else begin
      if (we1) begin
        mem[wa1] <= wd1;
      end
      if (we2) begin
        mem[wa2] <= wd2;
      end
    end
  end

  assign bus_rdata = rdata_r;
  assign running = state_r != ST_IDLE;
  assign illegal_op = ill_r;

endmodule : scx_core

//--- sim/scx_core_properties.sv
// Port-level assertions for the execution core
`timescale 1ns/1ps
module scx_core_properties import scx_pkg::*; (
  input wire logic clock,
  input wire logic reset_n,
  input wire scx_bus_req_t bus_req,
  input wire logic [7:0] bus_rdata,
  input wire logic running,
  input wire logic illegal_op
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic ctl_go;
  logic ill_clr;
  assign ctl_go = bus_req.wr && bus_req.addr == REG_CTRL && bus_req.wdata[CTRL_RUN_BIT];
  assign ill_clr = bus_req.wr && bus_req.addr == REG_STATUS && bus_req.wdata[STAT_ILL_BIT];
  a_rdata_quiet: assert property (!$past(bus_req.rd) |-> bus_rdata == 8'h00)
    else $error("read data outside reply");
  a_unmapped_zero: assert property ($past(bus_req.rd && bus_req.addr[3]) |-> bus_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_status_live: assert property ($past(bus_req.rd && bus_req.addr == REG_STATUS) |->
    bus_rdata[3:0] == {2'b00, $past(illegal_op), $past(running)})
    else $error("status low bits wrong");
  a_run_go: assert property (!running && ctl_go |-> ##2 running)
    else $error("run command ignored");
  a_run_cause: assert property ($rose(running) |-> $past(ctl_go, 2))
    else $error("core started unasked");
  a_ill_halt: assert property ($rose(illegal_op) |-> ##[0:8] !running)
    else $error("core ran on after bad opcode");
  a_ill_sticky: assert property (illegal_op && !ill_clr |=> illegal_op)
    else $error("bad opcode flag lost");
  a_ill_clear: assert property (illegal_op && !running && ill_clr |=> !illegal_op)
    else $error("bad opcode flag not cleared");
endmodule : scx_core_properties

bind scx_core scx_core_properties u_props (
  .clock(clock),
  .reset_n(reset_n),
  .bus_req(bus_req),
  .bus_rdata(bus_rdata),
  .running(running),
  .illegal_op(illegal_op)
);

//--- sim/scx_core_bench.sv
// Self-checking bench for the execution core
`timescale 1ns/1ps
module scx_core_bench import scx_pkg::*; ;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  scx_bus_req_t bus_req = '0;
  logic [7:0] bus_rdata;
  logic running;
  logic illegal_op;
  logic rd_d = 1'b0;
  logic tk;
  logic [7:0] a, b, m, n, f;
  logic [7:0] exp_q[$];
  int bad_count = 0;
  int checked = 0;
  int seed = 32'h12b31afa;
  int base = 0;
  int clk_n;

  always #50 clock = ~clock;

  scx_core uut (
    .clock(clock),
    .reset_n(reset_n),
    .bus_req(bus_req),
    .bus_rdata(bus_rdata),
    .running(running),
    .illegal_op(illegal_op)
  );

  task automatic print_verdict;
    if (bad_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [11:0] seen, input logic [11:0] want);
    checked++;
    if (seen !== want) begin
      bad_count++;
      $display("[ERR] %0t saw %h want %h", $time, seen, want);
    end
  endtask : check

  // Reply stands only in the cycle after the strobe
  always @(posedge clock) begin
    if (rd_d) check({4'h0, bus_rdata}, {4'h0, exp_q.pop_front()});
    rd_d <= bus_req.rd;
  end

  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    bus_req <= {ad, d, 2'b10};
    @(posedge clock);
  endtask : wr

  task automatic rd(input logic [3:0] ad, input logic [7:0] e);
    exp_q.push_back(e);
    bus_req <= {ad, 8'h00, 2'b01};
    @(posedge clock);
  endtask : rd

  task automatic poke(input logic [7:0] ad, input logic [7:0] d);
    wr(REG_MEM_ADDR, ad);
    wr(REG_MEM_DATA, d);
  endtask : poke

  // Every program ends on an unused opcode, so the halt point is known
  task automatic run(input logic [7:0] p[$], input int cyc, input bit tim);
    wr(REG_STATUS, 8'h02);
    wr(REG_MEM_ADDR, 8'h00);
    foreach (p[i]) wr(REG_MEM_DATA, p[i]);
    wr(REG_PC, 8'h00);
    wr(REG_STACK, 8'hF0);
    wr(REG_CTRL, 8'h01);
    bus_req <= '0;
    clk_n = 0;
    @(negedge clock);
    // Start takes two clocks: run flag, then first fetch
    while (running !== 1'b1 && clk_n < 8) begin
      clk_n++;
      @(negedge clock);
    end
    if (running !== 1'b1) clk_n = 2000;
    while (running === 1'b1 && clk_n < 2000) begin
      clk_n++;
      @(negedge clock);
    end
    if (clk_n >= 2000) begin
      bad_count++;
      print_verdict;
    end
    check({11'h000, illegal_op}, 12'h001);
    if (tim) check(12'(clk_n - base), 12'(4 * cyc));
    else base = clk_n;
    @(posedge clock);
  endtask : run

  initial begin
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    rd(4'h9, 8'h00);
    rd(REG_STACK, 8'hFF);
    run('{8'hFF}, 0, 1'b0);
    rd(REG_STATUS, 8'h02);
    for (int i = 0; i < 16; i++) begin
      a = 8'($random(seed) & 3);
      b = 8'($random(seed) & 3);
      tk = (i % 4 == 0) ? a == b : (i % 4 == 1) ? a != b : (i % 4 == 2) ? a < b : a >= b;
      run('{8'h20, a, 8'h1A, b, 8'h01 + 8'(i % 4), 8'h02, 8'hFF, 8'hFF, 8'hFF}, 6 + tk, 1'b1);
      rd(REG_PC, tk ? 8'h08 : 8'h06);
      rd(REG_STATUS, {a == b, 2'b00, a < b, 4'h2});
    end
    for (int i = 0; i < 8; i++) begin
      m = 8'($random(seed));
      poke(8'h18, m);
      tk = m[i] ^ i[0];
      run('{8'h05 + 8'(i % 2), {5'h18, 3'(i)}, 8'h03, 8'hFF, 8'hFF, 8'hFF, 8'hFF}, 3 + tk, 1'b1);
      rd(REG_PC, tk ? 8'h06 : 8'h03);
    end
    for (int v = 1; v < 4; v++) begin
      run('{8'h30, 8'(v), 8'h08, 8'h02, 8'hFF, 8'hFF, 8'hFF}, 6 + (v == 1), 1'b1);
      rd(REG_PC, v == 1 ? 8'h06 : 8'h04);
    end
    // Negative displacement wraps below address zero
    poke(8'h18, 8'h5A);
    poke(8'hFE, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      n = i[1] ? 8'h5A : 8'h18;
      tk = i[0] ? n != 8'h18 : n != 8'h5A;
      run('{8'h21, 8'h18, 8'h0C + 8'(i % 2), n, 8'hF9, 8'hFF}, 5 + tk, 1'b1);
      rd(REG_PC, tk ? 8'hFE : 8'h05);
    end
    run('{8'h10, 8'h08, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h12}, 7, 1'b1);
    rd(REG_PC, 8'h02);
    rd(REG_STACK, 8'hF0);
    poke(8'h10, 8'hFF);
    poke(8'hF0, 8'h00);
    run('{8'h11}, 4, 1'b1);
    rd(REG_PC, ZERO_PAGE_VECTOR);
    rd(REG_STACK, 8'hEE);
    wr(REG_MEM_ADDR, 8'hF0);
    rd(REG_MEM_DATA, 8'h02);
    for (int i = 0; i < 3; i++) begin
      n = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
      run('{8'h1F, n, 8'hFF}, n + 3, 1'b1);
    end
    a = 8'($random(seed));
    m = 8'($random(seed));
    n = 8'($random(seed));
    poke(8'h18, m);
    wr(REG_MEM_DATA, n);
    run('{8'h21, 8'h18, 8'h20, a, 8'h18, 8'h1C, 8'h1D, 8'h19, 8'hFF}, 8, 1'b1);
    f = a & m & n;
    rd(REG_ACC, f);
    rd(REG_STATUS, {f == 8'h00, 2'b00, a < m, 4'h2});
    run('{8'h21, 8'h18, 8'h20, 8'h19, 8'h1B, 8'hFF}, 8, 1'b1);
    rd(REG_ACC, 8'h19);
    rd(REG_STATUS, {m == n, 2'b00, m < n, 4'h2});
    b = 8'($random(seed));
    run('{8'h20, a, 8'h1A, b, 8'h15, 8'h13, 8'h20, 8'h00, 8'h14, 8'hFF}, 13, 1'b1);
    wr(REG_ACC, ~a);
    rd(REG_ACC, a);
    rd(REG_STACK, 8'hF0);
    rd(REG_STATUS, {2'b10, a < b, ^a, 4'h2});
    wr(REG_MEM_ADDR, 8'hEF);
    rd(REG_MEM_DATA, {4'h0, a == b, 1'b0, a < b, ^a});
    rd(REG_ACC, a);
    run('{8'h22, b, 8'h00, 8'h20, a, 8'h1E, b, 8'hFF}, 7, 1'b1);
    rd(REG_ACC, a & b);
    rd(REG_STATUS, {(a & b) == 8'h00, 1'b0, a < b, ^a, 4'h2});
    // Reset in mid-program must drop back to idle with registers cleared and the stack pointer back at RESET_SP
    wr(REG_STATUS, 8'h02);
    wr(REG_PC, 8'h00);
    wr(REG_MEM_ADDR, 8'h00);
    wr(REG_MEM_DATA, 8'h1F);
    wr(REG_MEM_DATA, 8'hFF);
    wr(REG_CTRL, 8'h01);
    bus_req <= '0;
    repeat (20) @(posedge clock);
    check({10'h000, running, illegal_op}, 12'h002);
    reset_n <= 1'b0;
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    check({10'h000, running, illegal_op}, 12'h000);
    rd(REG_CTRL, 8'h00);
    rd(REG_PC, 8'h00);
    rd(REG_STACK, RESET_SP);
    rd(REG_STATUS, 8'h00);
    bus_req <= '0;
    repeat (3) @(posedge clock);
    print_verdict;
  end
endmodule : scx_core_bench
